// [clock_module_pkg.sv]
// Constants and types shared by the clock generation block
package clock_module_pkg;

    // ----------------------------------------------------------------
    // Clock rate and times
    // ----------------------------------------------------------------
    localparam int SYS_FREQ_KHZ = 125000;
    localparam int MISS_TIME_NS = 1000;
    localparam int SYS_PERIOD_NS = 8;
    localparam int MISS_CYCLES = (MISS_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int LIMP_FREQ_KHZ = 2500;
    localparam int LIMP_HALF_CYCLES = SYS_FREQ_KHZ / (2 * LIMP_FREQ_KHZ);

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int RATIO_W = 4;
    localparam int CNT_W = 16;
    localparam logic [3:0] RATIO_RESET = 4'h0;
    localparam logic [3:0] RATIO_MAX = 4'hc;
    localparam logic [1:0] POST_DIVIDER_SELECT_RESET = 2'h0;
    localparam logic [1:0] CORE_SRC_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Post-divider codes
    // ----------------------------------------------------------------
    localparam logic [1:0] POST_DIVIDER_SELECT_BY2 = 2'h2;
    localparam logic [1:0] POST_DIVIDER_SELECT_BY1 = 2'h3;
    localparam logic [1:0] DIV_LIMIT_BY4 = 2'h3;
    localparam logic [1:0] DIV_LIMIT_BY2 = 2'h1;
    localparam logic [1:0] DIV_LIMIT_BY1 = 2'h0;

    // ----------------------------------------------------------------
    // Core source codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_OSC_ONE = 2'h0;
    localparam logic [1:0] SRC_OSC_TWO = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;

    // ----------------------------------------------------------------
    // Pin inputs to synchronise
    // ----------------------------------------------------------------
    localparam int PIN_N = 5;
    localparam int PIN_OSC_ONE = 0;
    localparam int PIN_OSC_TWO = 1;
    localparam int PIN_XTAL = 2;
    localparam int PIN_EXT_A = 3;
    localparam int PIN_EXT_B = 4;

    // ----------------------------------------------------------------
    // PLL modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_BYPASS = 2'b00,
        ST_LOCKING = 2'b01,
        ST_ENABLED = 2'b11,
        ST_OFF = 2'b10
    } pll_mode_e;

endpackage : clock_module_pkg

// [rate_multiplier.sv]
// Edge-rate multiplier standing in for the PLL oscillator
`timescale 1ns/1ps
module rate_multiplier
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Source edges and ratio
    input wire logic edge_i,
    input wire logic [clock_module_pkg::RATIO_W-1:0] ratio_i,
    // Multiplied edges
    output logic tick_o
);

    logic [clock_module_pkg::CNT_W-1:0] count;
    logic [clock_module_pkg::CNT_W-1:0] period;
    logic [clock_module_pkg::CNT_W-1:0] acc;
    logic [clock_module_pkg::CNT_W-1:0] next_acc;

    // ----------------------------------------------------------------
    // Source period measurement
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count <= '0;
            period <= '1;
        end
        else if (edge_i)
        begin
            count <= '0;
            period <= count + 16'h1;
        end
        else if (count != '1)
        begin
            count <= count + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Ratio edges per source edge
    // ----------------------------------------------------------------
    always_comb
    begin
        next_acc = acc + {12'h0, ratio_i};
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc <= '0;
            tick_o <= 1'b0;
        end
        else if (next_acc >= period)
        begin
            acc <= next_acc - period;
            tick_o <= 1'b1;
        end
        else
        begin
            acc <= next_acc;
            tick_o <= 1'b0;
        end
    end

endmodule : rate_multiplier

// [pll_clock_ctrl.sv]
// PLL clock generation with missing-clock detection and limp mode
`timescale 1ns/1ps
module pll_clock_ctrl
#(
    parameter int LOCK_EDGES = 8192,
    parameter int NMI_WD_CYCLES = 65535
)
(
    // Clock and resets
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic WDOG_RST_I,
    input wire logic DBG_RST_I,
    // Oscillator and clock pins
    input wire logic OSC_ONE_I,
    input wire logic OSC_TWO_I,
    input wire logic XTAL_I,
    input wire logic EXT_PIN_A_I,
    input wire logic EXT_PIN_B_I,
    // Protected writes
    input wire logic PROT_WR_EN_I,
    input wire logic RATIO_WR_I,
    input wire logic [3:0] RATIO_DATA_I,
    input wire logic STATUS_WR_I,
    input wire logic [1:0] POST_DIVIDER_SELECT_DATA_I,
    input wire logic PLL_OFF_DATA_I,
    input wire logic CTRL_WR_I,
    input wire logic [1:0] CORE_SRC_DATA_I,
    input wire logic WDOG_SRC_DATA_I,
    input wire logic TIMER2_SRC_DATA_I,
    input wire logic EXT_OFF_DATA_I,
    input wire logic FAIL_RST_SEL_DATA_I,
    input wire logic EXT_SEL_WR_I,
    input wire logic EXT_SEL_DATA_I,
    // Flag clears
    input wire logic MCLK_CLR_I,
    input wire logic NMI_CLR_I,
    // Clocks out
    output logic CPU_CLK_O,
    output logic SYS_CLK_OUT_O,
    output logic WDOG_CLK_O,
    output logic TIMER2_CLK_O,
    // Status
    output logic [3:0] RATIO_O,
    output logic [1:0] POST_DIVIDER_SELECT_O,
    output logic LOCK_O,
    output logic PLL_OFF_O,
    output logic BYPASS_O,
    output logic MISSING_CLK_O,
    output logic LIMP_O,
    output logic NMI_O,
    output logic RESET_REQ_O
);

    localparam int CNT_W = clock_module_pkg::CNT_W;
    clock_module_pkg::pll_mode_e mode;
    clock_module_pkg::pll_mode_e next_mode;
    logic [clock_module_pkg::PIN_N-1:0] pin_meta;
    logic [clock_module_pkg::PIN_N-1:0] pin_sync;
    logic [1:0] core_src;
    logic wdog_src;
    logic timer2_src;
    logic ext_off;
    logic ext_sel;
    logic fail_rst_sel;
    logic ext_clk;
    logic osc_level;
    logic osc_prev;
    logic osc_edge;
    logic mult_tick;
    logic pre_edge;
    logic [1:0] div_cnt;
    logic [clock_module_pkg::CNT_W-1:0] lock_cnt;
    logic [clock_module_pkg::CNT_W-1:0] miss_cnt;
    logic [clock_module_pkg::CNT_W-1:0] limp_cnt;
    logic [clock_module_pkg::CNT_W-1:0] nmi_cnt;
    logic limp_tick;
    logic lost;
    logic ratio_wr;
    logic status_wr;
    logic ctrl_wr;
    logic core_rst;

    function automatic logic [1:0] div_limit(input logic [1:0] sel);
        case (sel)
            clock_module_pkg::POST_DIVIDER_SELECT_BY2: div_limit = clock_module_pkg::DIV_LIMIT_BY2;
            clock_module_pkg::POST_DIVIDER_SELECT_BY1: div_limit = clock_module_pkg::DIV_LIMIT_BY1;
            default: div_limit = clock_module_pkg::DIV_LIMIT_BY4;
        endcase
    endfunction : div_limit

    // ----------------------------------------------------------------
    // Write qualification
    // ----------------------------------------------------------------
    assign ratio_wr = RATIO_WR_I & PROT_WR_EN_I;
    assign status_wr = STATUS_WR_I & PROT_WR_EN_I;
    assign ctrl_wr = CTRL_WR_I & PROT_WR_EN_I;
    assign core_rst = WDOG_RST_I | DBG_RST_I;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < clock_module_pkg::PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta[gi] <= (gi == clock_module_pkg::PIN_OSC_ONE) ? OSC_ONE_I :
                                    (gi == clock_module_pkg::PIN_OSC_TWO) ? OSC_TWO_I :
                                    (gi == clock_module_pkg::PIN_XTAL) ? XTAL_I :
                                    (gi == clock_module_pkg::PIN_EXT_A) ? EXT_PIN_A_I :
                                    EXT_PIN_B_I;
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    always_comb
    begin
        ext_clk = ext_sel ? pin_sync[clock_module_pkg::PIN_EXT_B]
                          : pin_sync[clock_module_pkg::PIN_EXT_A];
        ext_clk = ext_clk & ~ext_off;
        case (core_src)
            clock_module_pkg::SRC_OSC_ONE: osc_level = pin_sync[clock_module_pkg::PIN_OSC_ONE];
            clock_module_pkg::SRC_OSC_TWO: osc_level = pin_sync[clock_module_pkg::PIN_OSC_TWO];
            clock_module_pkg::SRC_XTAL: osc_level = pin_sync[clock_module_pkg::PIN_XTAL];
            default: osc_level = ext_clk;
        endcase
    end

    assign osc_edge = osc_level ^ osc_prev;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            osc_prev <= 1'b0;
            WDOG_CLK_O <= 1'b0;
            TIMER2_CLK_O <= 1'b0;
        end
        else
        begin
            osc_prev <= osc_level;
            WDOG_CLK_O <= wdog_src ? pin_sync[clock_module_pkg::PIN_OSC_TWO]
                                   : pin_sync[clock_module_pkg::PIN_OSC_ONE];
            TIMER2_CLK_O <= timer2_src ? pin_sync[clock_module_pkg::PIN_OSC_TWO]
                                       : pin_sync[clock_module_pkg::PIN_OSC_ONE];
        end
    end

    // ----------------------------------------------------------------
    // Clock control and external clock control
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            core_src <= clock_module_pkg::CORE_SRC_RESET;
            wdog_src <= 1'b0;
            timer2_src <= 1'b0;
            ext_off <= 1'b0;
            fail_rst_sel <= 1'b0;
            ext_sel <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            core_src <= CORE_SRC_DATA_I;
            wdog_src <= WDOG_SRC_DATA_I;
            timer2_src <= TIMER2_SRC_DATA_I;
            ext_off <= EXT_OFF_DATA_I;
            fail_rst_sel <= FAIL_RST_SEL_DATA_I;
        end
        else if (EXT_SEL_WR_I & PROT_WR_EN_I)
        begin
            ext_sel <= EXT_SEL_DATA_I;
        end
    end

    // ----------------------------------------------------------------
    // Ratio and status registers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            RATIO_O <= clock_module_pkg::RATIO_RESET;
            POST_DIVIDER_SELECT_O <= clock_module_pkg::POST_DIVIDER_SELECT_RESET;
            PLL_OFF_O <= 1'b0;
        end
        else if (WDOG_RST_I)
        begin
            RATIO_O <= clock_module_pkg::RATIO_RESET;
            POST_DIVIDER_SELECT_O <= clock_module_pkg::POST_DIVIDER_SELECT_RESET;
            PLL_OFF_O <= 1'b0;
        end
        else
        begin
            if (ratio_wr && RATIO_DATA_I <= clock_module_pkg::RATIO_MAX)
            begin
                RATIO_O <= RATIO_DATA_I;
            end
            if (status_wr)
            begin
                POST_DIVIDER_SELECT_O <= POST_DIVIDER_SELECT_DATA_I;
                PLL_OFF_O <= PLL_OFF_DATA_I;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lock period counter
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lock_cnt <= '0;
            LOCK_O <= 1'b0;
        end
        else if (WDOG_RST_I || ratio_wr)
        begin
            lock_cnt <= '0;
            LOCK_O <= 1'b0;
        end
        else if (osc_edge && !LOCK_O)
        begin
            lock_cnt <= lock_cnt + 16'h1;
            LOCK_O <= (lock_cnt == CNT_W'(LOCK_EDGES - 1));
        end
    end

    // ----------------------------------------------------------------
    // PLL mode
    // ----------------------------------------------------------------
    always_comb
    begin
        next_mode = mode;
        case (mode)
            clock_module_pkg::ST_BYPASS:
                if (PLL_OFF_O) next_mode = clock_module_pkg::ST_OFF;
                else if (ratio_wr && RATIO_DATA_I != '0) next_mode = clock_module_pkg::ST_LOCKING;
            clock_module_pkg::ST_LOCKING:
                if (PLL_OFF_O) next_mode = clock_module_pkg::ST_OFF;
                else if (RATIO_O == '0) next_mode = clock_module_pkg::ST_BYPASS;
                else if (LOCK_O) next_mode = clock_module_pkg::ST_ENABLED;
            clock_module_pkg::ST_ENABLED:
                if (PLL_OFF_O) next_mode = clock_module_pkg::ST_OFF;
                else if (ratio_wr) next_mode = (RATIO_DATA_I == '0) ?
                    clock_module_pkg::ST_BYPASS : clock_module_pkg::ST_LOCKING;
            clock_module_pkg::ST_OFF:
                if (!PLL_OFF_O) next_mode = clock_module_pkg::ST_BYPASS;
            default:
                next_mode = clock_module_pkg::ST_BYPASS;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mode <= clock_module_pkg::ST_BYPASS;
            BYPASS_O <= 1'b1;
        end
        else if (WDOG_RST_I)
        begin
            mode <= clock_module_pkg::ST_BYPASS;
            BYPASS_O <= 1'b1;
        end
        else
        begin
            mode <= next_mode;
            BYPASS_O <= (next_mode != clock_module_pkg::ST_ENABLED);
        end
    end

    // ----------------------------------------------------------------
    // Multiplier
    // ----------------------------------------------------------------
    rate_multiplier u_mult
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .edge_i(osc_edge),
        .ratio_i(RATIO_O),
        .tick_o(mult_tick)
    );

    // ----------------------------------------------------------------
    // Missing clock detection and limp clock
    // ----------------------------------------------------------------
    assign lost = (miss_cnt >= CNT_W'(clock_module_pkg::MISS_CYCLES));
    assign limp_tick = (limp_cnt == CNT_W'(clock_module_pkg::LIMP_HALF_CYCLES - 1));

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            miss_cnt <= '0;
            limp_cnt <= '0;
        end
        else
        begin
            // Held clear while powered down, so waking gives no false loss
            miss_cnt <= (osc_edge || mode == clock_module_pkg::ST_OFF) ? '0
                        : (lost ? miss_cnt : miss_cnt + 16'h1);
            limp_cnt <= limp_tick ? '0 : limp_cnt + 16'h1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            LIMP_O <= 1'b0;
            MISSING_CLK_O <= 1'b0;
            NMI_O <= 1'b0;
            RESET_REQ_O <= 1'b0;
            nmi_cnt <= '0;
        end
        else if (core_rst)
        begin
            LIMP_O <= 1'b0;
            MISSING_CLK_O <= 1'b0;
            NMI_O <= 1'b0;
            RESET_REQ_O <= 1'b0;
            nmi_cnt <= '0;
        end
        else
        begin
            if (lost && !LIMP_O && mode != clock_module_pkg::ST_OFF)
            begin
                LIMP_O <= 1'b1;
            end
            else if (LIMP_O && !lost && !MISSING_CLK_O)
            begin
                LIMP_O <= 1'b0;
            end
            // Set wins over clear
            MISSING_CLK_O <= (lost && !LIMP_O && mode != clock_module_pkg::ST_OFF)
                             | (MISSING_CLK_O & ~MCLK_CLR_I);
            NMI_O <= (lost && !LIMP_O && mode != clock_module_pkg::ST_OFF)
                     | (NMI_O & ~NMI_CLR_I);
            RESET_REQ_O <= (fail_rst_sel && lost && !LIMP_O
                            && mode != clock_module_pkg::ST_OFF)
                           || (!fail_rst_sel && NMI_O
                               && nmi_cnt == CNT_W'(NMI_WD_CYCLES - 1));
            nmi_cnt <= (NMI_O && !fail_rst_sel && !NMI_CLR_I) ? nmi_cnt + 16'h1 : '0;
        end
    end

    // ----------------------------------------------------------------
    // Post-divider and clock outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        if (LIMP_O)
            pre_edge = limp_tick;
        else if (mode == clock_module_pkg::ST_ENABLED)
            pre_edge = mult_tick;
        else
            pre_edge = osc_edge;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            div_cnt <= '0;
            CPU_CLK_O <= 1'b0;
            SYS_CLK_OUT_O <= 1'b0;
        end
        else if (pre_edge)
        begin
            if (div_cnt >= div_limit(POST_DIVIDER_SELECT_O))
            begin
                div_cnt <= '0;
                CPU_CLK_O <= ~CPU_CLK_O;
                SYS_CLK_OUT_O <= ~CPU_CLK_O;
            end
            else
            begin
                div_cnt <= div_cnt + 2'h1;
            end
        end
    end

endmodule : pll_clock_ctrl

// [pll_clock_ctrl_properties.sv]
// Concurrent property checker for the PLL clock block
`timescale 1ns/1ps
module pll_clock_ctrl_properties
(
    // Clock and resets
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic WDOG_RST_I,
    // Writes
    input wire logic PROT_WR_EN_I,
    input wire logic RATIO_WR_I,
    input wire logic [3:0] RATIO_DATA_I,
    input wire logic STATUS_WR_I,
    input wire logic [1:0] POST_DIVIDER_SELECT_DATA_I,
    // Outputs watched
    input wire logic CPU_CLK_O,
    input wire logic SYS_CLK_OUT_O,
    input wire logic [3:0] RATIO_O,
    input wire logic [1:0] POST_DIVIDER_SELECT_O,
    input wire logic LOCK_O,
    input wire logic PLL_OFF_O,
    input wire logic BYPASS_O,
    input wire logic MISSING_CLK_O,
    input wire logic LIMP_O,
    input wire logic NMI_O,
    input wire logic RESET_REQ_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    logic ratio_ok;
    assign ratio_ok = PROT_WR_EN_I && RATIO_WR_I && RATIO_DATA_I <= 4'hc && !WDOG_RST_I;

    AST_RATIO_TAKEN: assert property (ratio_ok |=> RATIO_O == $past(RATIO_DATA_I) && !LOCK_O)
        else $error("ratio write not taken");
    AST_POST_DIVIDER_SELECT_TAKEN: assert property (PROT_WR_EN_I && STATUS_WR_I && !WDOG_RST_I
        |=> POST_DIVIDER_SELECT_O == $past(POST_DIVIDER_SELECT_DATA_I)) else $error("divider write not taken");
    AST_PROT_HOLD: assert property (!PROT_WR_EN_I && !WDOG_RST_I
        |=> $stable(RATIO_O) && $stable(POST_DIVIDER_SELECT_O) && $stable(PLL_OFF_O)) else $error("unprotected write");
    AST_ZERO_BYPASS: assert property (RATIO_O == 4'h0 [*2] |-> BYPASS_O)
        else $error("ratio zero without bypass");
    AST_UNLOCKED_BYPASS: assert property (!LOCK_O [*2] |-> BYPASS_O)
        else $error("multiplied clock before lock");
    AST_LIMP_FLAGS: assert property ($rose(LIMP_O) |-> MISSING_CLK_O && NMI_O)
        else $error("limp entry without flags");
    AST_RESET_PULSE: assert property (RESET_REQ_O |=> !RESET_REQ_O)
        else $error("reset request longer than one cycle");
    AST_OUT_COPY: assert property (SYS_CLK_OUT_O == CPU_CLK_O)
        else $error("system clock differs from cpu clock");

    cover property ($rose(LOCK_O));
    cover property ($rose(LIMP_O));
    cover property (RESET_REQ_O);
endmodule : pll_clock_ctrl_properties

bind pll_clock_ctrl pll_clock_ctrl_properties chk_u (.SYS_CLK_I, .RST_N_I, .WDOG_RST_I,
    .PROT_WR_EN_I, .RATIO_WR_I, .RATIO_DATA_I, .STATUS_WR_I, .POST_DIVIDER_SELECT_DATA_I, .CPU_CLK_O,
    .SYS_CLK_OUT_O, .RATIO_O, .POST_DIVIDER_SELECT_O, .LOCK_O, .PLL_OFF_O, .BYPASS_O, .MISSING_CLK_O,
    .LIMP_O, .NMI_O, .RESET_REQ_O);

// [pll_clock_ctrl_tb_top.sv]
// Self-checking testbench for the PLL clock block
`timescale 1ns/1ps
module pll_clock_ctrl_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wdr = 1'b0, dbr = 1'b0, o1 = 1'b0, o2 = 1'b0, run = 1'b1;
    logic pe = 1'b0, rw = 1'b0, sw = 1'b0, cw = 1'b0, ew = 1'b0, mc = 1'b0, nc = 1'b0;
    logic [7:0] d = 8'h00;
    logic [7:0] gap = 8'h00;
    logic cpu, sys, wdc, tmc, lock, off, byp, miss, limp, nmi, rreq;
    logic [3:0] ratio;
    logic [1:0] post_divider_select;
    logic [23:0] st;
    logic [15:0] rnd = 16'hfb93;
    int n_mismatch = 0, checked = 0, oc = 0;
    typedef struct {string n; int lsb; logic [7:0] m; logic [7:0] e;} note_s;
    note_s notes[$];
    note_s cur;
    assign st = {gap, sys ^ cpu, tmc, wdc, rreq, nmi, miss, limp, off, byp, lock, post_divider_select, ratio};

    pll_clock_ctrl #(.LOCK_EDGES(8), .NMI_WD_CYCLES(16)) dut_u (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .WDOG_RST_I(wdr), .DBG_RST_I(dbr),
        .OSC_ONE_I(o1), .OSC_TWO_I(o2), .XTAL_I(o1), .EXT_PIN_A_I(1'b0), .EXT_PIN_B_I(o1),
        .PROT_WR_EN_I(pe), .RATIO_WR_I(rw), .RATIO_DATA_I(d[3:0]), .STATUS_WR_I(sw),
        .POST_DIVIDER_SELECT_DATA_I(d[1:0]), .PLL_OFF_DATA_I(d[2]), .CTRL_WR_I(cw),
        .CORE_SRC_DATA_I(d[1:0]), .WDOG_SRC_DATA_I(d[2]), .TIMER2_SRC_DATA_I(d[3]),
        .EXT_OFF_DATA_I(d[4]), .FAIL_RST_SEL_DATA_I(d[5]), .EXT_SEL_WR_I(ew),
        .EXT_SEL_DATA_I(d[6]), .MCLK_CLR_I(mc), .NMI_CLR_I(nc), .CPU_CLK_O(cpu),
        .SYS_CLK_OUT_O(sys), .WDOG_CLK_O(wdc), .TIMER2_CLK_O(tmc), .RATIO_O(ratio),
        .POST_DIVIDER_SELECT_O(post_divider_select), .LOCK_O(lock), .PLL_OFF_O(off), .BYPASS_O(byp),
        .MISSING_CLK_O(miss), .LIMP_O(limp), .NMI_O(nmi), .RESET_REQ_O(rreq));

    // --------
    // Clock and oscillator
    // --------
    always #4 clk = ~clk;
    always @(negedge clk)
        if (run)
        begin
            oc = (oc + 1) % 4;
            if (oc == 0)
                o1 <= ~o1;
        end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic note(input string n, input int lsb, input logic [7:0] m, e);
        notes.push_back('{n, lsb, m, e});
    endtask : note

    task automatic put(input int kind, input logic prot, input logic [7:0] v);
        @(negedge clk);
        pe = prot;
        d = v;
        rw = (kind == 0);
        sw = (kind == 1);
        cw = (kind == 2);
        ew = (kind == 3);
        @(negedge clk);
        {rw, sw, cw, ew} = 4'h0;
    endtask : put

    task automatic wait_lv(ref logic s, input logic lv, input int n);
        for (int j = 0; j < n && s !== lv; j++)
            @(negedge clk);
    endtask : wait_lv

    task automatic measure;
        logic last;
        int n;
        for (int j = 0; j < 3; j++)
        begin
            last = cpu;
            n = 0;
            while (cpu === last && n < 250)
            begin
                @(negedge clk);
                n++;
            end
        end
        gap = 8'(n);
        note("sys", 15, 8'h1, 8'h0);
    endtask : measure

    task automatic recover;
        run = 1'b1;
        repeat (30) @(negedge clk);
        {mc, nc} = 2'h3;
        @(negedge clk);
        {mc, nc} = 2'h0;
        wait_lv(limp, 1'b0, 100);
        note("limp", 9, 8'h1, 8'h0);
    endtask : recover

    task automatic print_verdict;
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // --------
    // Checking
    // --------
    initial forever
    begin
        @(negedge clk);
        #1;
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            check(cur.n, 8'(st >> cur.lsb) & cur.m, cur.e);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        logic [3:0] v;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        note("ratio", 0, 8'hf, 8'h0);
        note("div", 4, 8'h3, 8'h0);
        note("byp", 7, 8'h1, 8'h1);
        put(0, 1'b0, 8'h05);
        note("ratio", 0, 8'hf, 8'h0);
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr_next(rnd);
            v = (i == 0) ? 4'h1 : (i == 1) ? 4'hd : (i == 2) ? 4'hc : 4'(rnd % 16'hc) + 4'h1;
            put(0, 1'b1, {4'h0, v});
            note("ratio", 0, 8'hf, (i == 1) ? 8'h1 : {4'h0, v});
            note("lock", 6, 8'h1, 8'h0);
            note("byp", 7, 8'h1, 8'h1);
        end
        wait_lv(lock, 1'b1, 400);
        note("lock", 6, 8'h1, 8'h1);
        repeat (2) @(negedge clk);
        note("byp", 7, 8'h1, 8'h0);
        put(0, 1'b1, 8'h00);
        wait_lv(lock, 1'b1, 400);
        for (int i = 0; i < 4; i++)
        begin
            put(1, 1'b1, 8'(i));
            measure();
            note("gap", 16, 8'hff, (i < 2) ? 8'h10 : 8'(16 >> (i - 1)));
        end
        put(1, 1'b1, 8'h00);
        put(0, 1'b1, 8'h02);
        wait_lv(lock, 1'b1, 400);
        repeat (2) @(negedge clk);
        measure();
        note("gap", 16, 8'hff, 8'h08);
        put(1, 1'b1, 8'h02);
        dbr = 1'b1;
        @(negedge clk);
        dbr = 1'b0;
        note("ratio", 0, 8'hf, 8'h2);
        note("lock", 6, 8'h1, 8'h1);
        wdr = 1'b1;
        @(negedge clk);
        wdr = 1'b0;
        note("ratio", 0, 8'hf, 8'h0);
        note("div", 4, 8'h3, 8'h0);
        for (int s = 0; s < 2; s++)
        begin
            put(2, 1'b1, 8'(s << 5));
            run = 1'b0;
            wait_lv(limp, 1'b1, 300);
            note("miss", 10, 8'h1, 8'h1);
            note("nmi", 11, 8'h1, 8'h1);
            note("rreq", 12, 8'h1, 8'(s));
            wait_lv(rreq, 1'b1, 40);
            note("rreq", 12, 8'h1, 8'h1);
            measure();
            note("gap", 16, 8'hff, 8'h64);
            recover();
        end
        put(1, 1'b1, 8'h04);
        note("off", 8, 8'h1, 8'h1);
        run = 1'b0;
        repeat (200) @(negedge clk);
        note("limp", 9, 8'h1, 8'h0);
        run = 1'b1;
        put(1, 1'b1, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            put(2, 1'b1, 8'(4 << s));
            o2 = 1'b1;
            repeat (5) @(negedge clk);
            note("src", 13 + s, 8'h1, 8'h1);
            o2 = 1'b0;
            repeat (5) @(negedge clk);
            note("src", 13 + s, 8'h1, 8'h0);
        end
        put(3, 1'b1, 8'h40);
        for (int s = 2; s < 4; s++)
        begin
            put(2, 1'b1, 8'(s));
            repeat (200) @(negedge clk);
            note("limp", 9, 8'h1, 8'h0);
        end
        put(2, 1'b1, 8'h13);
        wait_lv(limp, 1'b1, 300);
        note("limp", 9, 8'h1, 8'h1);
        put(2, 1'b1, 8'h00);
        recover();
        print_verdict();
    end
endmodule : pll_clock_ctrl_tb_top
